// ### hw/maam_access.sv
`timescale 1ns/10ps
`default_nettype none
`include "maam_consts.svh"

// Functional notes
// - Write-enable flag resets to 0 refusing writes; 1 permits writes.
// - Reads of reachable elements are served regardless of the flag.
// - Registers 1000-1999 map elements 0-999 as 16-bit unsigned integers.
// - Registers 2000-2999 map elements 0-999 as 32-bit floats.
// - Read uses code 3, write code 16; writes only via 16.
// - Integer write keeps fraction; integer read returns integer only.
// - Float writes convert to 32.16 fixed; float reads convert back.
// - Only elements 0-999 are reachable; the rest of the table is hidden.
// - Writes address the table linearly across user array boundaries.
module maam_access (
    input  wire logic               mclk,
    input  wire logic               rst_n,
    input  wire logic               array_write_enable_setting,
    input  wire logic               req_valid,
    output logic                    req_ready,
    input  wire maam_pkg::maam_req_t req,
    output logic                    rsp_valid,
    input  wire logic               rsp_ready,
    output maam_pkg::maam_rsp_t     rsp,
    output logic                    write_enabled
);

    localparam int AW = 12;

    // ------------------------------------------------------------
    // Conversion functions
    // ------------------------------------------------------------
    function automatic logic [`MAAM_ELEM_W-1:0] flt_to_fix(
        input logic [31:0] f);
        logic [7:0]               e;
        logic [`MAAM_ELEM_W-1:0]  m;
        logic [`MAAM_ELEM_W-1:0]  r;
        int                       sh;
        e  = f[30:23];
        m  = {24'h000000, 1'b1, f[22:0]};
        sh = int'(e) - `MAAM_F2X_BIAS;
        if (e == 8'h00) begin
            r = '0;
        end else if (sh >= 24) begin
            r = `MAAM_FIX_SAT;
        end else if (sh >= 0) begin
            r = m << sh;
        end else if (sh > -25) begin
            r = m >> (-sh);
        end else begin
            r = '0;
        end
        if (f[31]) begin
            r = -r;
        end
        return r;
    endfunction

    function automatic logic [31:0] fix_to_flt(
        input logic [`MAAM_ELEM_W-1:0] v);
        logic [`MAAM_ELEM_W-1:0] a;
        logic [`MAAM_ELEM_W-1:0] n;
        int                      p;
        a = v[`MAAM_ELEM_W-1] ? -v : v;
        p = 0;
        for (int i = 0; i < `MAAM_ELEM_W; i++) begin
            if (a[i]) begin
                p = i;
            end
        end
        n = (p >= 23) ? (a >> (p - 23)) : (a << (23 - p));
        if (a == '0) begin
            return 32'h00000000;
        end
        // Truncates below 24 significant bits instead of rounding
        return {v[`MAAM_ELEM_W-1], 8'(p + `MAAM_X2F_BIAS), n[22:0]};
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    maam_pkg::maam_state_t state_r;
    maam_pkg::maam_state_t state_nxt;
    maam_pkg::maam_rsp_t   rsp_r;
    maam_pkg::maam_rsp_t   rsp_nxt;
    logic                  we_flag_r;
    logic                  rd_flt_r;
    logic [7:0]            rd_fc_r;
    logic [`MAAM_ELEM_W-1:0] mem_rdata;

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    wire logic        take     = req_valid && (state_r == maam_pkg::MAAM_IDLE);
    wire logic [15:0] int_off  = req.addr - `MAAM_INT_BASE;
    wire logic [15:0] flt_off  = req.addr - `MAAM_FLT_BASE;
    wire logic        in_int   = (req.addr >= `MAAM_INT_BASE) &&
                                 (int_off < `MAAM_RANGE_LEN);
    wire logic        in_flt   = (req.addr >= `MAAM_FLT_BASE) &&
                                 (flt_off < `MAAM_RANGE_LEN);
    wire logic        qty_ok   = in_int ? (req.qty == `MAAM_INT_QTY)
                                        : (req.qty == `MAAM_FLT_QTY);
    wire logic        addr_ok  = (in_int || in_flt) && qty_ok;
    wire logic        is_rd    = (req.fc == `MAAM_FC_READ);
    wire logic        is_wr    = (req.fc == `MAAM_FC_WRITE);
    wire logic [AW-1:0] elem   = in_int ? int_off[AW-1:0] : flt_off[AW-1:0];
    wire logic        rd_go    = take && is_rd && addr_ok;
    wire logic        wr_go    = take && is_wr && addr_ok && we_flag_r;
    wire logic        wr_refd  = take && is_wr && addr_ok && !we_flag_r;
    wire logic        bad_fc   = take && !is_rd && !is_wr;
    wire logic        bad_addr = take && (is_rd || is_wr) && !addr_ok;

    // Write data shaping for both views
    // float to fixed
    wire logic [`MAAM_ELEM_W-1:0] wr_word = in_int
        ? {16'h0000, req.wdata[15:0], 16'h0000}
        : flt_to_fix(req.wdata);
    wire logic        mem_we_int  = wr_go;
    wire logic        mem_we_frac = wr_go && in_flt;

    // Read data shaping for both views
    wire logic [31:0] rd_int  = {16'h0000,
                                 mem_rdata[`MAAM_FRAC_W+15:`MAAM_FRAC_W]};
    wire logic [31:0] rd_flt  = fix_to_flt(mem_rdata);

    assign req_ready     = (state_r == maam_pkg::MAAM_IDLE);
    assign rsp_valid     = (state_r == maam_pkg::MAAM_RESP);
    assign rsp           = rsp_r;
    assign write_enabled = we_flag_r;

    // ------------------------------------------------------------
    // Array table
    // ------------------------------------------------------------
    // Element index is the linear table position, not a user array
    // linear table addressing
    maam_table_mem #(
        .DEPTH (`MAAM_TABLE_DEPTH),
        .AW    (AW)
    ) u_mem (
        .mclk    (mclk),
        .addr    (elem),
        .we_int  (mem_we_int),
        .we_frac (mem_we_frac),
        .wdata   (wr_word),
        .rdata   (mem_rdata)
    );

    // ------------------------------------------------------------
    // Next state and answer
    // ------------------------------------------------------------
    // One outstanding access; a single master means no arbitration
    // single master assumed
    always_comb begin
        state_nxt = state_r;
        rsp_nxt   = rsp_r;
        unique case (state_r)
            maam_pkg::MAAM_IDLE: begin
                rsp_nxt.fc    = req.fc;
                rsp_nxt.rdata = 32'h00000000;
                rsp_nxt.exc   = 1'b0;
                rsp_nxt.code  = 8'h00;
                if (rd_go) begin
                    state_nxt = maam_pkg::MAAM_READ;
                end else if (take) begin
                    state_nxt   = maam_pkg::MAAM_RESP;
                    rsp_nxt.exc = bad_fc || bad_addr || wr_refd;
                    rsp_nxt.code = bad_fc ? `MAAM_EXC_FUNC :
                                   bad_addr ? `MAAM_EXC_ADDR :
                                   wr_refd ? `MAAM_EXC_REFUSED : 8'h00;
                end
            end
            maam_pkg::MAAM_READ: begin
                rsp_nxt.rdata = rd_flt_r ? rd_flt : rd_int;
                rsp_nxt.fc    = rd_fc_r;
                state_nxt     = maam_pkg::MAAM_RESP;
            end
            maam_pkg::MAAM_RESP: begin
                if (rsp_ready) begin
                    state_nxt = maam_pkg::MAAM_IDLE;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // flag resets to refuse
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            we_flag_r <= `MAAM_WE_RST;
        end else begin
            we_flag_r <= array_write_enable_setting;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= maam_pkg::MAAM_IDLE;
            rsp_r    <= '0;
            rd_flt_r <= 1'b0;
            rd_fc_r  <= 8'h00;
        end else begin
            state_r  <= state_nxt;
            rsp_r    <= rsp_nxt;
            rd_flt_r <= rd_go ? in_flt : rd_flt_r;
            rd_fc_r  <= rd_go ? req.fc : rd_fc_r;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    wr_refused_a: assert property (
        (take && is_wr && addr_ok && !we_flag_r) |->
        !mem_we_int && !mem_we_frac
        ##1 rsp_valid && rsp.exc && rsp.code == `MAAM_EXC_REFUSED)
        else $error("write went through while disabled");

    rd_served_a: assert property (
        rd_go |-> ##2 rsp_valid && !rsp.exc)
        else $error("read not answered in two cycles");

    int_range_a: assert property (
        (take && in_int) |-> !in_flt &&
        req.addr < `MAAM_INT_BASE + `MAAM_RANGE_LEN &&
        elem == AW'(req.addr - `MAAM_INT_BASE))
        else $error("integer range decoded wrongly");

    flt_range_a: assert property (
        (take && in_flt) |-> elem < AW'(`MAAM_REACH_DEPTH) &&
        req.addr < `MAAM_FLT_BASE + `MAAM_RANGE_LEN &&
        elem == AW'(req.addr - `MAAM_FLT_BASE))
        else $error("float range decoded wrongly");

    fc_write_a: assert property (
        (take && !is_wr) |-> !mem_we_int)
        else $error("table written without code 16");

    fc_bad_a: assert property (
        bad_fc |=> rsp_valid && rsp.code == `MAAM_EXC_FUNC)
        else $error("foreign function code not refused");

    frac_keep_a: assert property (
        (wr_go && in_int) |-> mem_we_int && !mem_we_frac)
        else $error("integer write touched fraction");

    flt_whole_a: assert property (
        (wr_go && in_flt) |-> mem_we_int && mem_we_frac)
        else $error("float write not whole element");

    reach_lim_a: assert property (
        mem_we_int |-> elem < AW'(`MAAM_REACH_DEPTH))
        else $error("unreachable element written");

    flt_pair_a: assert property (
        (take && in_flt && (is_rd || is_wr) &&
         req.qty != `MAAM_FLT_QTY) |=>
        rsp_valid && rsp.code == `MAAM_EXC_ADDR)
        else $error("float access not a register pair");

    int_wr_c:  cover property (wr_go && in_int);
    flt_rd_c:  cover property (rd_go && in_flt ##2 rsp_valid);
    refused_c: cover property (wr_refd);

endmodule // maam_access

`default_nettype wire

// ### hw/maam_consts.svh
`ifndef MAAM_CONSTS_SVH
`define MAAM_CONSTS_SVH

// ----------------------------------------------------------------
// Function codes and exception codes
// ----------------------------------------------------------------
`define MAAM_FC_READ        8'h03
`define MAAM_FC_WRITE       8'h10
`define MAAM_EXC_FUNC       8'h01
`define MAAM_EXC_ADDR       8'h02
`define MAAM_EXC_REFUSED    8'h04

// ----------------------------------------------------------------
// Register ranges and table size
// ----------------------------------------------------------------
`define MAAM_INT_BASE       16'h03E8
`define MAAM_FLT_BASE       16'h07D0
`define MAAM_RANGE_LEN      16'h03E8
`define MAAM_TABLE_DEPTH    3000
`define MAAM_REACH_DEPTH    1000
`define MAAM_INT_QTY        8'h01
`define MAAM_FLT_QTY        8'h02

// ----------------------------------------------------------------
// Element layout (integer 32 bits, fraction 16 bits)
// ----------------------------------------------------------------
`define MAAM_INT_W          32
`define MAAM_FRAC_W         16
`define MAAM_ELEM_W         48
`define MAAM_WE_RST         1'b0

// ----------------------------------------------------------------
// Float conversion constants
// ----------------------------------------------------------------
`define MAAM_F2X_BIAS       134
`define MAAM_X2F_BIAS       111
`define MAAM_FIX_SAT        48'h7FFF_FFFF_FFFF

`endif

// ### hw/maam_pkg.sv
`default_nettype none

package maam_pkg;

    // Request from the Modbus transport, one access per request
    typedef struct packed {
        logic [7:0]  fc;
        logic [15:0] addr;
        logic [7:0]  qty;
        logic [31:0] wdata;
    } maam_req_t;

    // Answer to the transport
    typedef struct packed {
        logic        exc;
        logic [7:0]  fc;
        logic [7:0]  code;
        logic [31:0] rdata;
    } maam_rsp_t;

    typedef enum logic [1:0] {
        MAAM_IDLE,
        MAAM_READ,
        MAAM_RESP
    } maam_state_t;

endpackage

`default_nettype wire

// ### hw/maam_table_mem.sv
`timescale 1ns/10ps
`default_nettype none
`include "maam_consts.svh"

module maam_table_mem #(
    parameter int DEPTH = `MAAM_TABLE_DEPTH,
    parameter int AW    = 12
) (
    input  wire logic                    mclk,
    input  wire logic [AW-1:0]           addr,
    input  wire logic                    we_int,
    input  wire logic                    we_frac,
    input  wire logic [`MAAM_ELEM_W-1:0] wdata,
    output logic      [`MAAM_ELEM_W-1:0] rdata
);

    logic [`MAAM_INT_W-1:0]  int_mem  [DEPTH];
    logic [`MAAM_FRAC_W-1:0] frac_mem [DEPTH];

    // Separate lanes so an integer write never touches the fraction
    always_ff @(posedge mclk) begin
        if (we_int) begin
            int_mem[addr] <= wdata[`MAAM_ELEM_W-1:`MAAM_FRAC_W];
        end
        if (we_frac) begin
            frac_mem[addr] <= wdata[`MAAM_FRAC_W-1:0];
        end
        rdata <= {int_mem[addr], frac_mem[addr]};
    end

endmodule // maam_table_mem

`default_nettype wire

// ### verif/maam_master_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Single master on the request side of the access unit
// ----------------------------------------------------------------
module maam_master_model (
    input  wire logic                mclk,
    input  wire logic                req_ready,
    input  wire logic                rsp_valid,
    input  wire maam_pkg::maam_rsp_t rsp,
    output var logic                 req_valid,
    output var maam_pkg::maam_req_t  req,
    output var logic                 rsp_ready
);
    // Idle lines at time zero
    initial begin
        req_valid = 1'b0;
        req       = '0;
        rsp_ready = 1'b0;
    end

    task automatic access(input logic [7:0] fc, input logic [15:0] addr,
                          input logic [7:0] qty, input logic [31:0] wd,
                          input int stall,
                          output maam_pkg::maam_rsp_t got);
        @(posedge mclk);
        req_valid <= 1'b1;
        req       <= {fc, addr, qty, wd};
        do @(posedge mclk); while (req_ready !== 1'b1);
        // Released request shows no stale copy of the last one
        req_valid <= 1'b0;
        req       <= ~{fc, addr, qty, wd};
        do @(posedge mclk); while (rsp_valid !== 1'b1);
        // Slow consumer: answer must stand meanwhile
        repeat (stall) @(posedge mclk);
        rsp_ready <= 1'b1;
        @(posedge mclk);
        got = rsp;
        rsp_ready <= 1'b0;
    endtask
endmodule // maam_master_model

`default_nettype wire

// ### verif/maam_access_tb.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("Error %s expected %h seen %h", nm, exp, got); \
        end \
    end

module maam_access_tb;
    logic                mclk;
    logic                rst_n;
    logic                we_set;
    logic                req_valid;
    logic                req_ready;
    maam_pkg::maam_req_t req;
    logic                rsp_valid;
    logic                rsp_ready;
    maam_pkg::maam_rsp_t rsp;
    logic                write_enabled;
    int                  num_errors = 0;
    int                  total_checks = 0;
    int                  cycles = 0;

    // ------------------------------------------------------------
    // Clock, design and master
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    maam_access maam_access_inst (
        .mclk                       (mclk),
        .rst_n                      (rst_n),
        .array_write_enable_setting (we_set),
        .req_valid                  (req_valid),
        .req_ready                  (req_ready),
        .req                        (req),
        .rsp_valid                  (rsp_valid),
        .rsp_ready                  (rsp_ready),
        .rsp                        (rsp),
        .write_enabled              (write_enabled)
    );

    maam_master_model maam_master_model_inst (
        .mclk      (mclk),
        .req_ready (req_ready),
        .rsp_valid (rsp_valid),
        .rsp       (rsp),
        .req_valid (req_valid),
        .req       (req),
        .rsp_ready (rsp_ready)
    );

    // ------------------------------------------------------------
    // Shared access helpers
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Flag is registered once, so allow the lag before looking
    task automatic set_flag(input logic v);
        @(posedge mclk);
        we_set <= v;
        repeat (2) @(posedge mclk);
        #1;
        `CHK("write_enabled", v, write_enabled)
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] q,
                      input logic [31:0] d);
        maam_pkg::maam_rsp_t r;
        maam_master_model_inst.access(8'h10, a, q, d, 0, r);
        `CHK("write exc", 1'b0, r.exc)
        `CHK("write fc", 8'h10, r.fc)
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] q,
                      input logic [31:0] e, input int st);
        maam_pkg::maam_rsp_t r;
        maam_master_model_inst.access(8'h03, a, q, 32'h0000_0000, st, r);
        `CHK("read exc", 1'b0, r.exc)
        `CHK("read fc", 8'h03, r.fc)
        `CHK("read data", e, r.rdata)
    endtask

    task automatic bad(input logic [7:0] f, input logic [15:0] a,
                       input logic [7:0] q, input logic [7:0] c);
        maam_pkg::maam_rsp_t r;
        maam_master_model_inst.access(f, a, q, 32'h0000_0005, 0, r);
        `CHK("refused exc", 1'b1, r.exc)
        `CHK("refused code", c, r.code)
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        `CHK("req_ready", 1'b1, req_ready)
        `CHK("rsp_valid", 1'b0, rsp_valid)
        `CHK("write_enabled", 1'b0, write_enabled)
        $display("test_reset done");
    endtask

    // Upper write bits must not reach the element
    task automatic test_int_range();
        set_flag(1'b1);
        wr(16'h03E8, 8'h01, 32'hABCD_04D2);
        wr(16'h07CF, 8'h01, 32'h0000_FFFF);
        rd(16'h03E8, 8'h01, 32'h0000_04D2, 3);
        rd(16'h07CF, 8'h01, 32'h0000_FFFF, 0);
        $display("test_int_range done");
    endtask

    task automatic test_float_range();
        wr(16'h07D1, 8'h02, 32'h4124_0000);
        rd(16'h07D1, 8'h02, 32'h4124_0000, 0);
        rd(16'h03E9, 8'h01, 32'h0000_000A, 0);
        wr(16'h0BB7, 8'h02, 32'h4020_0000);
        rd(16'h0BB7, 8'h02, 32'h4020_0000, 2);
        rd(16'h07CF, 8'h01, 32'h0000_0002, 0);
        $display("test_float_range done");
    endtask

    // Integer write of 7 over 10.25 keeps the quarter
    task automatic test_keep_frac();
        wr(16'h03E9, 8'h01, 32'h0000_0007);
        rd(16'h07D1, 8'h02, 32'h40E8_0000, 0);
        $display("test_keep_frac done");
    endtask

    task automatic test_linear();
        wr(16'h03ED, 8'h01, 32'h0000_0011);
        wr(16'h03EE, 8'h01, 32'h0000_0022);
        rd(16'h03ED, 8'h01, 32'h0000_0011, 0);
        rd(16'h03EE, 8'h01, 32'h0000_0022, 0);
        $display("test_linear done");
    endtask

    task automatic test_bad_access();
        bad(8'h06, 16'h03E8, 8'h01, 8'h01);
        bad(8'h04, 16'h03E8, 8'h01, 8'h01);
        bad(8'h03, 16'h03E7, 8'h01, 8'h02);
        bad(8'h10, 16'h0BB8, 8'h02, 8'h02);
        bad(8'h10, 16'h03E8, 8'h02, 8'h02);
        bad(8'h03, 16'h07D0, 8'h01, 8'h02);
        rd(16'h03E8, 8'h01, 32'h0000_04D2, 0);
        $display("test_bad_access done");
    endtask

    // Writes refused while the flag is clear, reads still served
    task automatic test_refused();
        set_flag(1'b0);
        bad(8'h10, 16'h03E8, 8'h01, 8'h04);
        bad(8'h10, 16'h07D1, 8'h02, 8'h04);
        rd(16'h03E8, 8'h01, 32'h0000_04D2, 0);
        rd(16'h07D1, 8'h02, 32'h40E8_0000, 1);
        $display("test_refused done");
    endtask

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        rst_n  = 1'b0;
        we_set = 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1;
        test_reset();
        test_int_range();
        test_float_range();
        test_keep_frac();
        test_linear();
        test_bad_access();
        test_refused();
        end_of_test();
    end

    // Whole run needs under two hundred cycles; far above that is a hang
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            end_of_test();
        end
    end
endmodule // maam_access_tb

`default_nettype wire
